// >>> inc/smf_pkg.sv
// Constants for the supply monitor flag logic
package smf_pkg;
  // Register address and field positions
  localparam logic [7:0] CTRL_ADDR = 8'hdf;
  localparam logic [7:0] CTRL_RESET = 8'hde;
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned TRIP_LO_BIT = 3;
  localparam int unsigned TRIP_HI_BIT = 4;
  localparam int unsigned FLAG_BIT = 5;
  localparam int unsigned DCMP_BIT = 6;
  localparam logic [7:0] RSVD_MASK = 8'h86;
  localparam logic [7:0] RSVD_VALUE = 8'h86;
  // Trip select codes
  localparam logic [1:0] TRIP_4V37 = 2'h0;
  localparam logic [1:0] TRIP_3V08 = 2'h1;
  localparam logic [1:0] TRIP_2V93 = 2'h2;
  localparam logic [1:0] TRIP_2V63 = 2'h3;
  // Timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned HOLD_MS = 250;
  localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned GLITCH_NS = 1000;
  localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_W = 23;
  localparam int unsigned GLITCH_W = 5;
endpackage

// >>> tb/smf_supply_model.sv
// Partner model of the two supply comparators
`timescale 1ns/10ps
module smf_supply_model (
  input wire logic [1:0] trip_sel,
  input wire logic avdd_ok,
  input wire logic [31:0] dvdd_mv,
  output logic cmp_analog,
  output logic cmp_digital
);
  // Thresholds in millivolts, indexed by the trip code
  localparam int THR_MV[4] = '{4370, 3080, 2930, 2630};
  // trip point compare
  // Level outputs only; no hysteresis modelled, so dips are clean edges
  always_comb begin
    cmp_analog = avdd_ok;
    cmp_digital = dvdd_mv > THR_MV[trip_sel];
  end
endmodule // smf_supply_model

// >>> tb/smf_top_bench.sv
// Self-checking bench for the supply monitor flag logic
`timescale 1ns/10ps
module smf_top_bench;
  // Short hold-off so the timeout clear fits in a brief run
  localparam int unsigned HOLD = 50;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic irq_en = 1'b1;
  logic avdd_ok = 1'b1;
  int dvdd_mv = 5000;
  logic cmp_a, cmp_d, mon_en, flag, irq;
  logic [7:0] rdata;
  logic [1:0] trip;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #25 CLOCK = ~CLOCK;
  smf_top #(.HOLD_CYCLES(HOLD)) dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .SFR_ADDR(addr),
    .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .ANALOG_SUPPLY_COMPARE(cmp_a),
    .DIGITAL_SUPPLY_COMPARE(cmp_d), .SUPPLY_IRQ_ENABLE(irq_en), .SFR_RDATA(rdata),
    .SUPPLY_MONITOR_ENABLE(mon_en), .DIGITAL_TRIP_SELECT(trip), .SUPPLY_LOW_FLAG(flag),
    .SUPPLY_IRQ(irq));
  smf_supply_model model_u (.trip_sel(trip), .avdd_ok(avdd_ok), .dvdd_mv(dvdd_mv),
    .cmp_analog(cmp_a), .cmp_digital(cmp_d));
  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus tasks and closing report
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge CLOCK);
    wr = 1'b0;
  endtask
  // Read data is registered, so it is looked at one cycle after the strobe
  task rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge CLOCK);
    addr = a;
    rd = 1'b1;
    @(negedge CLOCK);
    rd = 1'b0;
    chk(rdata, exp);
  endtask
  task summarize;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(negedge CLOCK);
    RST_N = 1'b1;
    idle(4);
    rd_reg(8'hdf, smf_pkg::CTRL_RESET);
    rd_reg(8'h00, 8'h00);
    // Every trip code with the monitor off; 3.0 V sits between the codes
    dvdd_mv = 3000;
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'hdf, {3'h0, 2'(i), 3'h0});
      idle(4);
      chk(8'(trip), 8'(i));
      rd_reg(8'hdf, {1'b1, i >= 2, 1'b0, 2'(i), 3'h6});
    end
    wr_reg(8'hdf, 8'h00);
    idle(30);
    chk(8'(flag), 8'h00);
    chk(8'(mon_en), 8'h00);
    dvdd_mv = 5000;
    wr_reg(8'hdf, 8'h41);
    chk(8'(mon_en), 8'h01);
    idle(4);
    rd_reg(8'hdf, 8'hc7);
    // Ten-cycle dip: status follows it, the flag must not
    dvdd_mv = 3000;
    idle(8);
    rd_reg(8'hdf, 8'h87);
    dvdd_mv = 5000;
    idle(30);
    chk(8'(flag), 8'h00);
    avdd_ok = 1'b0;
    idle(30);
    chk(8'(flag), 8'h01);
    chk(8'(irq), 8'h01);
    wr_reg(8'hdf, 8'h01);
    idle(2);
    chk(8'(flag), 8'h01);
    // A short drop in mid count restarts the hold-off
    avdd_ok = 1'b1;
    idle(40);
    avdd_ok = 1'b0;
    idle(5);
    avdd_ok = 1'b1;
    idle(45);
    chk(8'(flag), 8'h01);
    idle(15);
    chk(8'(flag), 8'h00);
    chk(8'(irq), 8'h00);
    irq_en = 1'b0;
    wr_reg(8'hdf, 8'h21);
    idle(2);
    chk(8'(flag), 8'h01);
    chk(8'(irq), 8'h00);
    // Clear attempt inside a dip too short to set the flag by itself
    avdd_ok = 1'b0;
    idle(3);
    wr_reg(8'hdf, 8'h01);
    avdd_ok = 1'b1;
    idle(2);
    chk(8'(flag), 8'h01);
    wr_reg(8'hdf, 8'h01);
    idle(2);
    chk(8'(flag), 8'h00);
    summarize();
  end
endmodule // smf_top_bench

// >>> verilog/smf_glitch_filter.sv
// Low-level glitch filter for the combined comparator low signal
`timescale 1ns/10ps
module smf_glitch_filter (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic low_in,
  output logic low_out
);
  typedef struct packed {
    logic [smf_pkg::GLITCH_W-1:0] cnt;
    logic out;
  } smf_filt_t;

  smf_filt_t st_r;
  smf_filt_t st_nxt;

  localparam logic [smf_pkg::GLITCH_W-1:0] LAST = smf_pkg::GLITCH_W'(smf_pkg::GLITCH_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // glitch rejection
  // Low must persist for the full window; any high sample restarts it
  always_comb begin
    st_nxt = st_r;
    if (!low_in) begin
      st_nxt.cnt = '0;
      st_nxt.out = 1'b0;
    end else if (st_r.cnt == LAST) begin
      st_nxt.out = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign low_out = st_r.out;

  // A short dip never reaches the output
  AST_FILTER_WINDOW: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $rose(st_r.out) |-> $past(low_in, 1) && $past(low_in, 10) && $past(low_in, 20))
    else $error("filter output rose without a full low window");
endmodule // smf_glitch_filter

// >>> verilog/smf_top.sv
// Supply monitor control register, low-supply flag and hold-off timer
// What this block does
// - Monitor acts only while control bit 0 is one; zero disables it.
// - Two-bit field picks digital threshold: 4.37, 3.08, 2.93, 2.63 volts.
// - Bit 6 reads live digital comparator state; writes to it do nothing.
// - Flag bit 5 sets once either supply comparator has read low for 1000 ns.
// - Both high starts 250 ms count; a drop restarts it; timeout clears.
// - Software may write the flag; clearing is ignored while a supply is low.
// - Interrupt requested only when the flag and its enable are both set.
// - Short comparator dips must not raise the flag.
`timescale 1ns/10ps
module smf_top #(
  parameter int unsigned HOLD_CYCLES = smf_pkg::HOLD_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic ANALOG_SUPPLY_COMPARE,
  input wire logic DIGITAL_SUPPLY_COMPARE,
  input wire logic SUPPLY_IRQ_ENABLE,
  output logic [7:0] SFR_RDATA,
  output logic SUPPLY_MONITOR_ENABLE,
  output logic [1:0] DIGITAL_TRIP_SELECT,
  output logic SUPPLY_LOW_FLAG,
  output logic SUPPLY_IRQ
);
  typedef struct packed {
    logic [1:0] cmp_meta;
    logic [1:0] cmp_sync;
    logic enable;
    logic [1:0] trip;
    logic flag;
    logic [smf_pkg::HOLD_W-1:0] hold_cnt;
    logic [7:0] rdata;
    logic irq;
  } smf_state_t;

  smf_state_t st_r;
  smf_state_t st_nxt;
  logic any_low;
  logic filt_low;
  logic both_high;
  logic hit_wr;
  logic hit_rd;
  logic hold_done;
  logic mon_low;

  localparam logic [smf_pkg::HOLD_W-1:0] HOLD_LAST = smf_pkg::HOLD_W'(HOLD_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Decode from the raw bus; comparator condition from synchronised samples
  assign hit_wr = SFR_WR && (SFR_ADDR == smf_pkg::CTRL_ADDR);
  assign hit_rd = SFR_RD && (SFR_ADDR == smf_pkg::CTRL_ADDR);
  assign both_high = st_r.cmp_sync[0] && st_r.cmp_sync[1];
  assign any_low = !both_high;
  assign hold_done = both_high && (st_r.hold_cnt == HOLD_LAST);

  // filter idles while disabled
  // A low that ended before enable must not land the flag on the enabling write
  assign mon_low = any_low && st_r.enable;

  // Only the flag-setting path is filtered; status and timer see raw sync
  smf_glitch_filter u_filter (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .low_in(mon_low),
    .low_out(filt_low)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.cmp_meta = {DIGITAL_SUPPLY_COMPARE, ANALOG_SUPPLY_COMPARE};
    st_nxt.cmp_sync = st_r.cmp_meta;

    if (hit_wr) begin
      st_nxt.enable = SFR_WDATA[smf_pkg::EN_BIT];
      st_nxt.trip = SFR_WDATA[smf_pkg::TRIP_HI_BIT:smf_pkg::TRIP_LO_BIT];
    end

    // hold-off counter
    // Counter only runs while the flag waits to be released
    if (!st_r.enable || !st_r.flag || !both_high || hold_done) begin
      st_nxt.hold_cnt = '0;
    end else begin
      st_nxt.hold_cnt = st_r.hold_cnt + 1'b1;
    end

    if (st_r.enable && st_r.flag && hold_done) begin
      st_nxt.flag = 1'b0;
    end
    if (hit_wr) begin
      if (SFR_WDATA[smf_pkg::FLAG_BIT]) begin
        st_nxt.flag = 1'b1;
      end else if (both_high) begin
        st_nxt.flag = 1'b0;
      end
    end
    // hardware set
    // Set is applied last so it wins over any clear in the same cycle
    if (st_r.enable && filt_low) begin
      st_nxt.flag = 1'b1;
    end

    st_nxt.irq = st_nxt.flag && SUPPLY_IRQ_ENABLE;

    // reserved bits fixed
    // Unmapped reads return zero
    if (hit_rd) begin
      st_nxt.rdata = smf_pkg::RSVD_VALUE;
      st_nxt.rdata[smf_pkg::DCMP_BIT] = st_r.cmp_sync[1];
      st_nxt.rdata[smf_pkg::FLAG_BIT] = st_r.flag;
      st_nxt.rdata[smf_pkg::TRIP_HI_BIT:smf_pkg::TRIP_LO_BIT] = st_r.trip;
      st_nxt.rdata[smf_pkg::EN_BIT] = st_r.enable;
    end else if (SFR_RD) begin
      st_nxt.rdata = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset mirrors the control reset value
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
      st_r.enable <= smf_pkg::CTRL_RESET[smf_pkg::EN_BIT];
      st_r.trip <= smf_pkg::CTRL_RESET[smf_pkg::TRIP_HI_BIT:smf_pkg::TRIP_LO_BIT];
      st_r.flag <= smf_pkg::CTRL_RESET[smf_pkg::FLAG_BIT];
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign SFR_RDATA = st_r.rdata;
  assign SUPPLY_MONITOR_ENABLE = st_r.enable;
  assign DIGITAL_TRIP_SELECT = st_r.trip;
  assign SUPPLY_LOW_FLAG = st_r.flag;
  assign SUPPLY_IRQ = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking smf_cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  AST_DISABLED_NO_SET: assert property (
    !st_r.enable && !st_r.flag && !hit_wr |=> !SUPPLY_LOW_FLAG)
    else $error("flag set while monitor disabled");

  AST_TRIP_WRITE: assert property (
    hit_wr |=> DIGITAL_TRIP_SELECT ==
      $past(SFR_WDATA[smf_pkg::TRIP_HI_BIT:smf_pkg::TRIP_LO_BIT]))
    else $error("trip select did not follow write");

  AST_TRIP_HOLD: assert property (
    !hit_wr |=> $stable(DIGITAL_TRIP_SELECT))
    else $error("trip select changed without a write");

  // status bit is the comparator, not write data
  AST_STATUS_LIVE: assert property (
    hit_rd |=> SFR_RDATA[6] == $past(DIGITAL_SUPPLY_COMPARE, 3))
    else $error("status bit does not show comparator");

  AST_LOW_SETS: assert property (
    st_r.enable && filt_low |=> SUPPLY_LOW_FLAG)
    else $error("flag not set on low supply");

  AST_CLEAR_TIMEOUT: assert property (
    st_r.flag && !hit_wr && !hold_done |=> SUPPLY_LOW_FLAG)
    else $error("flag cleared before hold-off expired");

  // clear refused while a supply is low
  AST_SW_CLEAR_BLOCKED: assert property (
    hit_wr && !SFR_WDATA[5] && st_r.flag && any_low |=> SUPPLY_LOW_FLAG)
    else $error("software cleared flag during low supply");

  AST_IRQ_GATED: assert property (
    SUPPLY_IRQ == (SUPPLY_LOW_FLAG && $past(SUPPLY_IRQ_ENABLE)))
    else $error("interrupt without flag and enable");

  AST_SYNC_DEPTH: assert property (
    $past(RST_N, 2) |->
      st_r.cmp_sync == $past({DIGITAL_SUPPLY_COMPARE, ANALOG_SUPPLY_COMPARE}, 2))
    else $error("comparator sync depth wrong");

  AST_RSVD_FIXED: assert property (
    hit_rd |=> (SFR_RDATA & smf_pkg::RSVD_MASK) == smf_pkg::RSVD_VALUE)
    else $error("reserved bits not fixed");

  AST_UNMAPPED_READ: assert property (
    SFR_RD && !hit_rd |=> SFR_RDATA == 8'h00)
    else $error("unmapped read returned nonzero data");

  AST_RDATA_HOLD: assert property (
    !SFR_RD |=> $stable(SFR_RDATA))
    else $error("read data changed without a read");

  AST_SW_SET: assert property (
    hit_wr && SFR_WDATA[smf_pkg::FLAG_BIT] |=> SUPPLY_LOW_FLAG)
    else $error("software set of flag lost");

  AST_SW_CLEAR: assert property (
    hit_wr && !SFR_WDATA[smf_pkg::FLAG_BIT] && both_high && !filt_low |=> !SUPPLY_LOW_FLAG)
    else $error("software clear ignored with both supplies high");

  AST_ENABLE_WRITE: assert property (
    hit_wr |=> SUPPLY_MONITOR_ENABLE == $past(SFR_WDATA[smf_pkg::EN_BIT]))
    else $error("enable bit did not follow write");
endmodule // smf_top
